// file: logic/pcr_ctl.sv
// Modem card power-down sequencer, ring reporting and modem reset control
`default_nettype none
module pcr_ctl #(
  parameter int unsigned POR_CYCLES       = pcr_pkg::POR_CYCLES,
  parameter int unsigned WAKE_CYCLES      = pcr_pkg::WAKE_CYCLES,
  parameter int unsigned RING_HOLD_CYCLES = pcr_pkg::RING_HOLD_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire pcr_pkg::pcr_cfg_t cfg,
  input  wire logic              ring_event_clear,
  input  wire logic              io_access_valid,
  input  wire logic              socket_reset_in,
  input  wire logic              modem_ready_in,
  input  wire logic              line_ring_in,
  input  wire logic              modem_irq_in,
  output logic                   stop_request_high_out,
  output logic                   stop_request_n_out,
  output logic                   wake_ring_type_a_out,
  output logic                   wake_ring_type_b_out,
  output logic                   modem_select_n,
  output logic                   modem_reset_n,
  output logic                   ireq_n,
  output logic                   stschg_n,
  output logic                   ready_busy_flag,
  output logic                   ring_event_flag,
  output logic                   changed_bit,
  output logic                   memory_only_mode,
  output logic                   regs_default
);
  import pcr_pkg::*;

  typedef struct packed {
    pcr_state_t       st;
    logic [CNT_W-1:0] por_cnt;
    logic             por_done;
    logic             mdm_rdy_q;
    logic             ring_q;
    logic             pd_q;
    logic             rdy_busy;
    logic             ring_evt;
    logic             changed;
    logic             mem_only;
    logic             ireq_rdy;
    logic             ring_a;
    logic             ring_b;
    logic             stop_hi;
    logic             stop_n;
    logic             msel_n;
    logic             rst_out_n;
    logic             ireq_n;
    logic             stschg_n;
  } pcr_ctl_state_t;

  pcr_ctl_state_t s_r;
  pcr_ctl_state_t s_nxt;
  pcr_pins_t      pins_sync;
  pcr_cfg_t       cfg_eff;
  logic           in_reset;
  logic           pd;
  logic           mdm_rdy;
  logic           ring;
  logic           mdm_rdy_rise;
  logic           mdm_rdy_fall;
  logic           ring_rise;
  logic           pd_rise;
  logic           pd_fall;
  logic           wake_load;
  logic           wake_busy;
  logic           ring_active;

  if (POR_CYCLES < 1 || POR_CYCLES >= (1 << CNT_W)) begin : g_chk_por
    $error("pcr_ctl: POR_CYCLES out of range");
  end
  if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W)) begin : g_chk_wake
    $error("pcr_ctl: WAKE_CYCLES out of range");
  end
  if (RING_HOLD_CYCLES < 1 || RING_HOLD_CYCLES >= (1 << CNT_W)) begin : g_chk_ring
    $error("pcr_ctl: RING_HOLD_CYCLES out of range");
  end

  pcr_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .clock (clock),
    .srst  (srst),
    .d     ({socket_reset_in, modem_ready_in, line_ring_in, modem_irq_in}),
    .q     (pins_sync)
  );

  // Wake pulse width for type-A modems
  pcr_timer #(
    .WIDTH (CNT_W)
  ) u_wake_tmr (
    .clock (clock),
    .srst  (srst),
    .load  (wake_load),
    .value (CNT_W'(WAKE_CYCLES)),
    .busy  (wake_busy)
  );

  // Ring integrator: retriggered by every rising ring edge, outlasts one ring period
  pcr_timer #(
    .WIDTH (CNT_W)
  ) u_ring_tmr (
    .clock (clock),
    .srst  (srst),
    .load  (ring_rise),
    .value (CNT_W'(RING_HOLD_CYCLES)),
    .busy  (ring_active)
  );

  assign mdm_rdy   = pins_sync.modem_ready_in;
  assign ring      = pins_sync.line_ring_in;
  assign in_reset  = !s_r.por_done || pins_sync.socket_reset_in || cfg.soft_reset_bit;
  assign cfg_eff   = in_reset ? '0 : cfg;
  assign pd        = cfg_eff.power_down_req_bit;
  assign mdm_rdy_rise = mdm_rdy && !s_r.mdm_rdy_q;
  assign mdm_rdy_fall = !mdm_rdy && s_r.mdm_rdy_q;
  assign ring_rise = ring && !s_r.ring_q;
  assign pd_rise   = pd && !s_r.pd_q;
  assign pd_fall   = !pd && s_r.pd_q;

  always_comb begin
    s_nxt        = s_r;
    wake_load    = 1'b0;
    s_nxt.mdm_rdy_q = mdm_rdy;
    s_nxt.ring_q = ring;
    s_nxt.pd_q   = pd;

    if (!s_r.por_done) begin
      s_nxt.por_cnt = s_r.por_cnt + CNT_W'(1);
      if (s_r.por_cnt == CNT_W'(POR_CYCLES - 1)) begin
        s_nxt.por_done = 1'b1;
      end
    end

    unique case (s_r.st)
      ST_NORMAL: begin
        if (pd_rise) begin
          s_nxt.st = (cfg_eff.modem_type_b && !mdm_rdy) ? ST_PD_WAKE : ST_PD_HOLD;
        end
      end
      ST_PD_WAKE: begin
        if (pd_fall) begin
          s_nxt.st  = ST_UP_PULSE;
          wake_load = 1'b1;
        end else if (mdm_rdy) begin
          s_nxt.st = ST_PD_HOLD;
        end
      end
      ST_PD_HOLD: begin
        if (pd_fall) begin
          s_nxt.st  = ST_UP_PULSE;
          wake_load = 1'b1;
        end
      end
      ST_UP_PULSE: begin
        if (cfg_eff.modem_type_b ? mdm_rdy : !wake_busy) begin
          s_nxt.st = cfg_eff.modem_type_b ? ST_NORMAL : ST_UP_WAIT;
        end
      end
      ST_UP_WAIT: begin
        if (mdm_rdy) begin
          s_nxt.st = ST_NORMAL;
        end
      end
    endcase

    // Ready flag: event sets win over the power-down edge clears
    if (pd_rise || pd_fall) begin
      s_nxt.rdy_busy = 1'b0;
    end
    if ((pd && mdm_rdy_fall) || (!pd && mdm_rdy_rise)) begin
      s_nxt.rdy_busy = 1'b1;
    end

    s_nxt.ring_evt = ring_rise || (s_r.ring_evt && !ring_event_clear);
    if (cfg_eff.io_mode) begin
      s_nxt.mem_only = 1'b0;
    end
    if (mdm_rdy_rise) begin
      s_nxt.ireq_rdy = 1'b1;
    end

    if (in_reset) begin
      s_nxt.st       = ST_NORMAL;
      s_nxt.ring_evt = 1'b0;
      s_nxt.mem_only = 1'b1;
      s_nxt.ireq_rdy = 1'b0;
      s_nxt.rdy_busy = 1'b0;
    end

    unique case (s_nxt.st)
      ST_NORMAL: begin
        s_nxt.ring_a = !ring;
        s_nxt.ring_b = ring;
      end
      ST_PD_WAKE: begin
        s_nxt.ring_a = 1'b0;
        s_nxt.ring_b = 1'b1;
      end
      ST_PD_HOLD: begin
        s_nxt.ring_a = 1'b0;
        s_nxt.ring_b = 1'b0;
      end
      ST_UP_PULSE: begin
        s_nxt.ring_a = !cfg_eff.modem_type_b;
        s_nxt.ring_b = cfg_eff.modem_type_b;
      end
      ST_UP_WAIT: begin
        s_nxt.ring_a = 1'b0;
        s_nxt.ring_b = 1'b0;
      end
    endcase

    s_nxt.stop_hi  = pd;
    s_nxt.stop_n   = !pd;
    s_nxt.msel_n   = !(io_access_valid && cfg_eff.config_index_valid && !pd);
    s_nxt.rst_out_n = !in_reset;
    s_nxt.ireq_n   = s_nxt.mem_only ? s_nxt.ireq_rdy : !pins_sync.modem_irq_in;
    s_nxt.changed  = cfg_eff.ring_event_enable && s_nxt.ring_evt;
    s_nxt.stschg_n = cfg_eff.ring_passthru_enable ? !ring_active
                                                  : !(s_nxt.changed && cfg_eff.status_change_enable);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r          <= '0;
      s_r.st       <= ST_NORMAL;
      s_r.mem_only <= 1'b1;
      s_r.ring_a   <= 1'b1;
      s_r.stop_n   <= 1'b1;
      s_r.msel_n   <= 1'b1;
      s_r.stschg_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stop_request_high_out = s_r.stop_hi;
  assign stop_request_n_out    = s_r.stop_n;
  assign wake_ring_type_a_out  = s_r.ring_a;
  assign wake_ring_type_b_out  = s_r.ring_b;
  assign modem_select_n        = s_r.msel_n;
  assign modem_reset_n         = s_r.rst_out_n;
  assign ireq_n                = s_r.ireq_n;
  assign stschg_n              = s_r.stschg_n;
  assign ready_busy_flag       = s_r.rdy_busy;
  assign ring_event_flag       = s_r.ring_evt;
  assign changed_bit           = s_r.changed;
  assign memory_only_mode      = s_r.mem_only;
  assign regs_default          = in_reset;

  property p_stop_levels;
    @(posedge clock) disable iff (srst) pd |=> stop_request_high_out && !stop_request_n_out;
  endproperty
  a_stop_levels : assert property (p_stop_levels) else $error("stop request levels wrong");

  property p_ring_a_low;
    @(posedge clock) disable iff (srst) pd_rise && s_r.st == ST_NORMAL |=> (!wake_ring_type_a_out)[*2];
  endproperty
  a_ring_a_low : assert property (p_ring_a_low) else $error("type-A ring not low on power-down");

  property p_ring_b_wake;
    @(posedge clock) disable iff (srst)
      pd_rise && s_r.st == ST_NORMAL && cfg_eff.modem_type_b && !mdm_rdy |=> wake_ring_type_b_out;
  endproperty
  a_ring_b_wake : assert property (p_ring_b_wake) else $error("type-B wake pulse missing");

  property p_ring_b_quiet;
    @(posedge clock) disable iff (srst)
      pd_rise && s_r.st == ST_NORMAL && mdm_rdy |=> !wake_ring_type_b_out && !stop_request_n_out;
  endproperty
  a_ring_b_quiet : assert property (p_ring_b_quiet) else $error("type-B ring moved with modem ready");

  property p_busy_on_pd;
    @(posedge clock) disable iff (srst) pd_rise && !mdm_rdy_fall |=> !ready_busy_flag;
  endproperty
  a_busy_on_pd : assert property (p_busy_on_pd) else $error("ready flag not cleared on power-down");

  property p_select_blocked;
    @(posedge clock) disable iff (srst) pd || !cfg_eff.config_index_valid |=> modem_select_n;
  endproperty
  a_select_blocked : assert property (p_select_blocked) else $error("modem select during power-down");

  property p_type_a_wait_low;
    @(posedge clock) disable iff (srst) s_r.st == ST_UP_WAIT && !mdm_rdy && !in_reset |=> !wake_ring_type_a_out;
  endproperty
  a_type_a_wait_low : assert property (p_type_a_wait_low) else $error("type-A ring not low before ready");

  property p_ring_latch;
    @(posedge clock) disable iff (srst) ring_rise && !in_reset |=> ring_event_flag;
  endproperty
  a_ring_latch : assert property (p_ring_latch) else $error("ring edge not latched");

  property p_reset_out;
    @(posedge clock) disable iff (srst) in_reset |=> !modem_reset_n && !ring_event_flag;
  endproperty
  a_reset_out : assert property (p_reset_out) else $error("modem reset not asserted");

  property p_ireq_busy;
    @(posedge clock) disable iff (srst) in_reset ##1 !in_reset && !mdm_rdy_rise |=> !ireq_n;
  endproperty
  a_ireq_busy : assert property (p_ireq_busy) else $error("interrupt pin not busy after reset");
endmodule : pcr_ctl
`default_nettype wire

// file: logic/pcr_pkg.sv
// Package: constants, states and carriers of the modem card power, ring and reset controller
`default_nettype none
package pcr_pkg;
  localparam int unsigned CLK_KHZ          = 100_000;
  localparam int unsigned POR_TIME_MS      = 15;
  localparam int unsigned WAKE_TIME_MS     = 12;
  localparam int unsigned RING_HOLD_MS     = 100;
  localparam int unsigned POR_CYCLES       = CLK_KHZ * POR_TIME_MS;
  localparam int unsigned WAKE_CYCLES      = CLK_KHZ * WAKE_TIME_MS;
  localparam int unsigned RING_HOLD_CYCLES = CLK_KHZ * RING_HOLD_MS;
  localparam int unsigned CNT_W            = 24;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam int unsigned PIN_W            = 4;

  typedef enum logic [4:0] {
    ST_NORMAL   = 5'h01,
    ST_PD_WAKE  = 5'h02,
    ST_PD_HOLD  = 5'h04,
    ST_UP_PULSE = 5'h08,
    ST_UP_WAIT  = 5'h10
  } pcr_state_t;

  // Configuration bits held by the host register file
  typedef struct packed {
    logic power_down_req_bit;
    logic ring_event_enable;
    logic status_change_enable;
    logic ring_passthru_enable;
    logic soft_reset_bit;
    logic io_mode;
    logic config_index_valid;
    logic modem_type_b;
  } pcr_cfg_t;

  // Asynchronous pins, synchronised as one vector
  typedef struct packed {
    logic socket_reset_in;
    logic modem_ready_in;
    logic line_ring_in;
    logic modem_irq_in;
  } pcr_pins_t;
endpackage : pcr_pkg
`default_nettype wire

// file: logic/pcr_sync.sv
// Two-stage synchroniser for asynchronous pins
`default_nettype none
module pcr_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pcr_sync_state_t;

  pcr_sync_state_t s_r;
  pcr_sync_state_t s_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("pcr_sync: WIDTH must be at least 1");
  end

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule : pcr_sync
`default_nettype wire

// file: logic/pcr_timer.sv
// Loadable down-counter; busy while the count is not zero
`default_nettype none
module pcr_timer #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  output logic                  busy
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pcr_timer_state_t;

  pcr_timer_state_t s_r;
  pcr_timer_state_t s_nxt;

  if (WIDTH < 2) begin : g_chk
    $error("pcr_timer: WIDTH must be at least 2");
  end

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = value;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.cnt != '0);

  property p_load_busy;
    @(posedge clock) disable iff (srst) load && value != '0 |=> busy && s_r.cnt == $past(value);
  endproperty
  a_load_busy : assert property (p_load_busy) else $error("timer did not take its load value");
endmodule : pcr_timer
`default_nettype wire

// file: bench/pcr_modem_model.sv
// Behavioural modem controller on the far side of the power and ring controller
`default_nettype none
module pcr_modem_model #(
  parameter int DLY = 6
) (
  input  wire logic clock,
  input  wire logic type_b,
  input  wire logic sleep_cmd,
  input  wire logic irq_req,
  input  wire logic rst_n,
  input  wire logic stop_hi,
  input  wire logic stop_n,
  input  wire logic ring_a,
  input  wire logic ring_b,
  output var logic  ready,
  output var logic  irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode 0 booting, 1 awake, 2 asleep or stopped
  int   mode = 0;
  int   cnt  = DLY;
  logic ra_q = 1'b1;
  logic rb_q = 1'b0;
  logic stop_ok;
  logic wake_ev;
  // Stop entry needs the request and the ring line at its low level
  assign stop_ok = type_b ? (!stop_n && !ring_b) : (stop_hi && !ring_a);
  // Type B wakes on a rising ring, type A on a falling one
  assign wake_ev = type_b ? (ring_b && !rb_q) : (!ring_a && ra_q);
  initial ready = 1'b0;
  initial irq = 1'b0;
  always @(posedge clock) begin
    ra_q <= ring_a;
    rb_q <= ring_b;
    irq  <= irq_req;
    if (!rst_n) begin
      mode  <= 0;
      cnt   <= DLY;
      ready <= 1'b0;
    end else if (mode == 0) begin
      cnt <= cnt - 1;
      if (cnt == 0) begin
        mode  <= 1;
        ready <= 1'b1;
        cnt   <= DLY;
      end
    end else if (mode == 1) begin
      cnt <= stop_ok ? cnt - 1 : DLY;
      if (sleep_cmd || (stop_ok && cnt == 0)) begin
        mode  <= 2;
        ready <= 1'b0;
      end
    end else if (wake_ev) begin
      mode <= 0;
      cnt  <= DLY;
    end
  end
endmodule : pcr_modem_model
`default_nettype wire

// file: bench/test_pcr_ctl.sv
// Self-checking bench of the power, ring and reset controller
`default_nettype none
module test_pcr_ctl import pcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  localparam int WAKE = 10;
  localparam int HOLD = 30;
  localparam int DLY = 6;
  localparam int S_RST = 0;
  localparam int S_IREQ = 1;
  localparam int S_RDY = 2;
  localparam int S_RB = 3;
  logic     clock = 1'b0;
  logic     srst = 1'b1;
  pcr_cfg_t cfg = '0;
  logic     clr = 1'b0;
  logic     io_ok = 1'b0;
  logic     sock = 1'b0;
  logic     ring = 1'b0;
  logic     sleep_cmd = 1'b0;
  logic     irq_req = 1'b0;
  logic     mdm_rdy, mirq, st_hi, st_n, ra, rb, msel_n, mdm_rst_n, ireq_n, sts_n, rdy, evt, chg, mem, dflt;
  int       n_fail = 0;
  int       total_checks = 0;
  always #5 clock = ~clock;
  pcr_ctl #(.POR_CYCLES(POR), .WAKE_CYCLES(WAKE), .RING_HOLD_CYCLES(HOLD)) dut (
    .clock(clock), .srst(srst), .cfg(cfg), .ring_event_clear(clr), .io_access_valid(io_ok),
    .socket_reset_in(sock), .modem_ready_in(mdm_rdy), .line_ring_in(ring), .modem_irq_in(mirq),
    .stop_request_high_out(st_hi), .stop_request_n_out(st_n), .wake_ring_type_a_out(ra),
    .wake_ring_type_b_out(rb), .modem_select_n(msel_n), .modem_reset_n(mdm_rst_n), .ireq_n(ireq_n),
    .stschg_n(sts_n), .ready_busy_flag(rdy), .ring_event_flag(evt), .changed_bit(chg),
    .memory_only_mode(mem), .regs_default(dflt));
  pcr_modem_model #(.DLY(DLY)) u_modem (
    .clock(clock), .type_b(cfg.modem_type_b), .sleep_cmd(sleep_cmd), .irq_req(irq_req),
    .rst_n(mdm_rst_n), .stop_hi(st_hi), .stop_n(st_n), .ring_a(ra), .ring_b(rb), .ready(mdm_rdy), .irq(mirq));
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", what, lo, hi, got);
    end
  endtask : check_range
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  function automatic logic sig(input int i);
    case (i)
      S_RST: return mdm_rst_n;
      S_IREQ: return ireq_n;
      S_RDY: return rdy;
      S_RB: return rb;
      default: return ra;
    endcase
  endfunction : sig
  // Bounded wait for a level, then judged
  task automatic wait_sig(input string what, input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(i) !== v && k < lim) begin
      step(1);
      k++;
    end
    check_bit(what, v, sig(i));
  endtask : wait_sig
  // Ring pulses five cycles high, one every ten cycles, shorter than the hold time
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clock);
      ring <= 1'b1;
      repeat (5) @(posedge clock);
      ring <= 1'b0;
      repeat (4) @(posedge clock);
    end
    #1;
  endtask : burst
  task automatic clear_event;
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    step(3);
  endtask : clear_event
  task automatic t_reset;
    check_bit("reset rst_n", 1'b0, mdm_rst_n);
    check_bit("reset dflt", 1'b1, dflt);
    check_bit("reset ireq_n", 1'b0, ireq_n);
    check_bit("reset mem", 1'b1, mem);
    check_bit("reset ra", 1'b1, ra);
    step(POR - 2);
    check_bit("por rst_n", 1'b0, mdm_rst_n);
    wait_sig("por end", S_RST, 1'b1, 6);
    check_bit("por dflt", 1'b0, dflt);
    check_bit("busy ireq_n", 1'b0, ireq_n);
    wait_sig("ready ireq_n", S_IREQ, 1'b1, DLY + 10);
    @(posedge clock);
    cfg.io_mode <= 1'b1;
    irq_req <= 1'b1;
    step(7);
    check_bit("io mem", 1'b0, mem);
    check_bit("irq ireq_n", 1'b0, ireq_n);
    @(posedge clock);
    irq_req <= 1'b0;
    step(7);
    check_bit("no irq ireq_n", 1'b1, ireq_n);
    $display("test reset done");
  endtask : t_reset
  task automatic t_select;
    @(posedge clock);
    io_ok <= 1'b1;
    step(3);
    check_bit("no index msel_n", 1'b1, msel_n);
    @(posedge clock);
    cfg.config_index_valid <= 1'b1;
    step(3);
    check_bit("index msel_n", 1'b0, msel_n);
    $display("test select done");
  endtask : t_select
  task automatic t_event;
    @(posedge clock);
    cfg.ring_event_enable <= 1'b1;
    cfg.status_change_enable <= 1'b1;
    burst(1);
    check_bit("evt", 1'b1, evt);
    check_bit("chg", 1'b1, chg);
    check_bit("evt sts_n", 1'b0, sts_n);
    step(3);
    check_bit("evt kept", 1'b1, evt);
    clear_event();
    check_bit("evt cleared", 1'b0, evt);
    check_bit("cleared sts_n", 1'b1, sts_n);
    $display("test ring event done");
  endtask : t_event
  task automatic t_pass;
    burst(1);
    @(posedge clock);
    cfg.ring_passthru_enable <= 1'b1;
    burst(3);
    check_bit("burst sts_n", 1'b0, sts_n);
    step(HOLD + 6);
    check_bit("gap sts_n", 1'b1, sts_n);
    check_bit("gap chg", 1'b1, chg);
    @(posedge clock);
    cfg.ring_passthru_enable <= 1'b0;
    step(3);
    check_bit("off sts_n", 1'b0, sts_n);
    clear_event();
    $display("test pass-through done");
  endtask : t_pass
  task automatic t_pd(input logic tb, input logic asleep);
    int n;
    @(posedge clock);
    cfg.modem_type_b <= tb;
    sleep_cmd <= asleep;
    @(posedge clock);
    sleep_cmd <= 1'b0;
    step(8);
    @(posedge clock);
    cfg.power_down_req_bit <= 1'b1;
    step(2);
    check_bit("pd stop_hi", 1'b1, st_hi);
    check_bit("pd stop_n", 1'b0, st_n);
    check_bit("pd ra", 1'b0, ra);
    check_bit("pd rdy", 1'b0, rdy);
    check_bit("pd msel_n", 1'b1, msel_n);
    check_bit("pd rb", tb & asleep, rb);
    wait_sig("pd rb low", S_RB, 1'b0, DLY + 10);
    wait_sig("stop rdy", S_RDY, 1'b1, 3 * DLY + 20);
    burst(2);
    check_bit("pd ring ra", 1'b0, ra);
    check_bit("pd ring rb", 1'b0, rb);
    check_bit("pd evt", 1'b1, evt);
    clear_event();
    @(posedge clock);
    cfg.power_down_req_bit <= 1'b0;
    step(2);
    check_bit("up rdy", 1'b0, rdy);
    check_bit("up stop_hi", 1'b0, st_hi);
    check_bit("up stop_n", 1'b1, st_n);
    check_bit("up ring", 1'b1, tb ? rb : ra);
    if (tb) begin
      wait_sig("up rb low", S_RB, 1'b0, DLY + 10);
    end else begin
      n = 0;
      while (ra === 1'b1 && n < 40) begin
        step(1);
        n++;
      end
      check_range("wake pulse", WAKE - 2, WAKE + 1, n);
      wait_sig("up ra high", S_RB + 1, 1'b1, DLY + 10);
    end
    wait_sig("up rdy", S_RDY, 1'b1, 4);
    check_bit("up msel_n", 1'b0, msel_n);
    @(posedge clock);
    ring <= 1'b1;
    step(4);
    check_bit("pass ring", tb, tb ? rb : ra);
    @(posedge clock);
    ring <= 1'b0;
    step(4);
    check_bit("idle ring", !tb, tb ? rb : ra);
    $display("test power-down done");
  endtask : t_pd
  task automatic t_soft;
    @(posedge clock);
    cfg.soft_reset_bit <= 1'b1;
    wait_sig("soft rst", S_RST, 1'b0, 4);
    check_bit("soft dflt", 1'b1, dflt);
    @(posedge clock);
    cfg <= '{soft_reset_bit: 1'b1, default: 1'b0};
    step(3);
    check_bit("soft mem", 1'b1, mem);
    check_bit("soft ireq_n", 1'b0, ireq_n);
    check_bit("soft held", 1'b0, mdm_rst_n);
    @(posedge clock);
    cfg.soft_reset_bit <= 1'b0;
    wait_sig("soft release", S_RST, 1'b1, POR + 6);
    wait_sig("soft ireq_n", S_IREQ, 1'b1, DLY + 10);
    check_bit("soft stays mem", 1'b1, mem);
    $display("test soft reset done");
  endtask : t_soft
  task automatic t_sock;
    @(posedge clock);
    sock <= 1'b1;
    wait_sig("sock rst", S_RST, 1'b0, 6);
    check_bit("sock dflt", 1'b1, dflt);
    step(5);
    check_bit("sock held", 1'b0, mdm_rst_n);
    @(posedge clock);
    sock <= 1'b0;
    wait_sig("sock release", S_RST, 1'b1, POR + 8);
    wait_sig("sock ireq_n", S_IREQ, 1'b1, DLY + 10);
    $display("test socket reset done");
  endtask : t_sock
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    step(1);
    t_reset();
    t_select();
    t_event();
    t_pass();
    t_pd(1'b1, 1'b1);
    t_pd(1'b1, 1'b0);
    t_pd(1'b0, 1'b0);
    t_pd(1'b0, 1'b1);
    t_soft();
    t_sock();
    summarize();
  end
  // Run takes under a thousand cycles
  initial begin
    repeat (6000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule : test_pcr_ctl
`default_nettype wire
